// file: design/bd_index_map.sv
module bd_index_map
    import usb_bd_pkg::*;
(
    // Selection
    input  wire logic [1:0]          mode,
    input  wire logic [EP_W-1:0]     ep,
    input  wire logic                dir_in,
    input  wire logic                odd,
    // Result
    output logic      [BD_IDX_W-1:0] idx,
    output logic                     pp
);

    logic                ep0;
    logic [BD_IDX_W-1:0] ep_x;
    logic [BD_IDX_W-1:0] m0;
    logic [BD_IDX_W-1:0] m1;
    logic [BD_IDX_W-1:0] m2;
    logic [BD_IDX_W-1:0] m3;

    assign ep0  = (ep == '0);
    assign ep_x = BD_IDX_W'(ep);

    assign m0 = BD_IDX_W'({ep, dir_in});
    assign m1 = ep0 ? (dir_in ? BD_IDX_W'(2) : BD_IDX_W'(odd))
                    : BD_IDX_W'({ep_x, 1'b0} + BD_IDX_W'(1)
                                + BD_IDX_W'(dir_in));
    assign m2 = {ep, dir_in, odd};
    assign m3 = ep0 ? BD_IDX_W'(dir_in)
                    : BD_IDX_W'({ep, dir_in, odd} - BD_IDX_W'(2));

    assign idx = (mode == MODE_NONE)    ? m0 :
                 (mode == MODE_EP0_OUT) ? m1 :
                 (mode == MODE_ALL)     ? m2 : m3;

    // Single-descriptor endpoints never use the odd slot
    assign pp = (mode == MODE_ALL) ||
                (mode == MODE_ALL_BUT0 && !ep0) ||
                (mode == MODE_EP0_OUT && ep0 && !dir_in);

endmodule // bd_index_map

// file: design/usb_bd_pkg.sv
package usb_bd_pkg;

    // Table and count sizes
    localparam int EP_NUM     = 8;
    localparam int EP_W       = 3;
    localparam int BD_IDX_W   = 5;
    localparam int CNT_W      = 10;
    localparam int RAM_AW_DEF = 9;

    // Byte positions inside one four-byte descriptor
    localparam logic [1:0] BD_STAT = 2'h0;
    localparam logic [1:0] BD_CNT  = 2'h1;
    localparam logic [1:0] BD_ADRL = 2'h2;
    localparam logic [1:0] BD_ADRH = 2'h3;

    // Status byte fields
    localparam int ST_OWN    = 7;
    localparam int ST_TOG    = 6;
    localparam int ST_TEN    = 3;
    localparam int ST_STALL  = 2;
    localparam int ST_CNT_HI = 1;

    // Token PIDs
    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;

    // Buffering modes
    localparam logic [1:0] MODE_NONE     = 2'h0;
    localparam logic [1:0] MODE_EP0_OUT  = 2'h1;
    localparam logic [1:0] MODE_ALL      = 2'h2;
    localparam logic [1:0] MODE_ALL_BUT0 = 2'h3;

    // Register page: offsets within it, in words
    localparam logic [1:0] REG_CFG_OFF = 2'h0;
    localparam logic [1:0] REG_UST_OFF = 2'h1;

    // Config register fields
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_EN      = 2;
    localparam int CFG_PCLR    = 3;
    localparam int CFG_W       = 4;

    // Transfer status register: fields start at this bit
    localparam int UST_LO = 1;

    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_e;

    typedef struct packed {
        logic [3:0]      pid;
        logic [EP_W-1:0] ep;
    } tok_s;

    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic            dir_in;
        logic            odd;
    } xfer_s;

endpackage

// file: design/usb_buffer_descriptor_engine.sv
// The implementer's own choices: the Avalon-MM register port and the address map.
module usb_buffer_descriptor_engine
    import usb_bd_pkg::*;
#(
    parameter int                RAM_AW   = RAM_AW_DEF,
    parameter logic [RAM_AW-1:0] BDT_BASE = '0
)(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [RAM_AW+2:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Token from the serial engine
    input  wire logic        tok_valid,
    input  wire tok_s        tok,
    output logic             tok_ready,
    // OUT/SETUP data from the serial engine
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_empty,
    input  wire logic        rx_data1,
    output logic             rx_ready,
    // IN data to the serial engine
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_last,
    output logic             tx_empty,
    input  wire logic        tx_ready,
    // Handshake to the serial engine
    output logic             hs_valid,
    output hs_e              hs_code
);

    localparam int AVS_AW = RAM_AW + 3;

    typedef enum logic [3:0] {
        S_IDLE, S_STAT, S_CNT, S_ADRL, S_ADRH, S_RX,
        S_TXLD, S_TX, S_WBCNT, S_WBSTAT, S_HS
    } state_e;

    // Shared USB RAM holding descriptor table and buffers
    logic [7:0] ram [2**RAM_AW];

    state_e                state_r;
    tok_s                  tok_r;
    xfer_s                 xf_r;
    logic [BD_IDX_W-1:0]   idx_r;
    logic                  pp_r;
    logic [7:0]            stat_r;
    logic [CNT_W-1:0]      cap_r;
    logic [CNT_W-1:0]      cnt_r;
    logic [15:0]           base_r;
    logic                  own_r;
    logic                  acc_r;
    logic                  stall_r;
    logic                  ovf_r;
    logic                  hs_pend_r;
    hs_e                   hs_r;
    logic [7:0]            tx_data_r;
    logic [2*EP_NUM-1:0]   ptr_r;
    logic [CFG_W-1:0]      cfg_r;
    logic [EP_W+1:0]       ust_r;
    logic [31:0]           rdata_r;
    logic                  rd_done_r;

    // Token decode and descriptor selection
    logic                  dir_in_w;
    logic                  tok_ok;
    logic                  tok_take;
    logic                  ptr_bit;
    logic [BD_IDX_W-1:0]   idx_w;
    logic                  pp_w;
    logic                  setup_w;
    logic                  owned_w;

    assign dir_in_w = (tok.pid == PID_IN);
    assign tok_ok   = dir_in_w || tok.pid == PID_OUT
                      || tok.pid == PID_SETUP;
    assign tok_ready = ce && state_r == S_IDLE;
    assign tok_take  = tok_ready && tok_valid && tok_ok;
    assign ptr_bit   = ptr_r[{tok.ep, dir_in_w}];

    bd_index_map u_map (
        .mode   (cfg_r[CFG_MODE_LO +: 2]),
        .ep     (tok.ep),
        .dir_in (dir_in_w),
        .odd    (ptr_bit),
        .idx    (idx_w),
        .pp     (pp_w)
    );

    assign setup_w = (tok_r.pid == PID_SETUP);
    assign owned_w = stat_r[ST_OWN] && cfg_r[CFG_EN];

    // Engine side of the RAM
    logic [1:0]         fld;
    logic [RAM_AW-1:0]  desc_addr;
    logic [RAM_AW-1:0]  buf_addr;
    logic [RAM_AW-1:0]  eng_addr;
    logic [7:0]         eng_q;
    logic [7:0]         eng_wd;
    logic [7:0]         stat_wb;
    logic               eng_we;
    logic               eng_use;
    logic               full;
    logic               rx_byte;
    logic               tog_bad;

    assign fld = (state_r == S_CNT  || state_r == S_WBCNT) ? BD_CNT  :
                 (state_r == S_ADRL) ? BD_ADRL :
                 (state_r == S_ADRH) ? BD_ADRH : BD_STAT;
    assign desc_addr = BDT_BASE + RAM_AW'({idx_r, fld});
    // Start address taken as is; wraps within the RAM
    assign buf_addr  = base_r[RAM_AW-1:0] + RAM_AW'(cnt_r);
    assign eng_addr  = (state_r == S_RX || state_r == S_TXLD)
                       ? buf_addr : desc_addr;
    assign eng_q     = ram[eng_addr];

    assign full    = (cnt_r == cap_r);
    assign rx_byte = rx_valid && !rx_empty;
    assign tog_bad = stat_r[ST_TEN] && !setup_w
                     && (rx_data1 != stat_r[ST_TOG]);

    // Ownership dropped, bit 6 kept, PID and count returned
    assign stat_wb = {1'b0, stat_r[ST_TOG], tok_r.pid,
                      cnt_r[CNT_W-1:8]};

    assign eng_we = (state_r == S_RX && rx_byte && acc_r && !full)
                    || state_r == S_WBCNT || state_r == S_WBSTAT;
    assign eng_wd = (state_r == S_WBCNT)  ? cnt_r[7:0] :
                    (state_r == S_WBSTAT) ? stat_wb : rx_data;
    assign eng_use = eng_we || state_r == S_STAT || state_r == S_CNT
                     || state_r == S_ADRL || state_r == S_ADRH
                     || state_r == S_TXLD;

    // Streams toward the serial engine
    assign rx_ready = ce && state_r == S_RX;
    assign tx_valid = state_r == S_TX;
    assign tx_empty = (cap_r == '0);
    assign tx_last  = tx_empty || (cnt_r + CNT_W'(1) == cap_r);
    assign tx_data  = tx_data_r;
    assign hs_valid = state_r == S_HS;
    assign hs_code  = hs_r;

    // Bus decode
    logic               grant;
    logic               hit_ram;
    logic               hit_reg;
    logic               hit_cfg;
    logic               hit_ust;
    logic               bus_wr;
    logic [RAM_AW-1:0]  bus_ram_addr;
    logic [31:0]        rd_mux;

    assign grant    = ce && !eng_use;
    assign hit_ram  = !avs_address[AVS_AW-1];
    assign hit_reg  = avs_address[AVS_AW-1]
                      && avs_address[AVS_AW-2:4] == '0;
    assign hit_cfg  = hit_reg && avs_address[3:2] == REG_CFG_OFF;
    assign hit_ust  = hit_reg && avs_address[3:2] == REG_UST_OFF;
    assign bus_ram_addr = avs_address[RAM_AW+1:2];
    assign bus_wr   = avs_write && grant && hit_ram;
    assign rd_mux   = hit_ram ? 32'(ram[bus_ram_addr]) :
                      hit_cfg ? 32'(cfg_r) :
                      hit_ust ? 32'({ust_r, 1'b0}) : 32'h0000_0000;
    // Engine has the RAM first; writes wait in cycles the engine uses it or ce is low, reads always wait at least one cycle
    assign avs_waitrequest = avs_read  ? !(rd_done_r && ce) :
                             avs_write ? !grant : 1'b0;
    assign avs_readdata = rdata_r;

    // RAM has no reset: contents unknown until software fills it
    always_ff @(posedge clk) begin
        if (ce && eng_we) begin
            ram[eng_addr] <= eng_wd;
        end else if (bus_wr) begin
            ram[bus_ram_addr] <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_done_r <= 1'b0;
            rdata_r   <= '0;
        end else if (ce) begin
            rd_done_r <= avs_read && grant && !rd_done_r;
            if (avs_read && grant && !rd_done_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r <= '0;
        end else if (avs_write && grant && hit_cfg) begin
            cfg_r <= avs_writedata[CFG_W-1:0];
        end
    end

    // Pointers reset to even while disabled or cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_r <= '0;
            ust_r <= '0;
        end else if (ce) begin
            if (!cfg_r[CFG_EN] || cfg_r[CFG_PCLR]) begin
                ptr_r <= '0;
            end else if (state_r == S_WBSTAT && pp_r) begin
                ptr_r[{xf_r.ep, xf_r.dir_in}] <=
                    !ptr_r[{xf_r.ep, xf_r.dir_in}];
            end
            if (state_r == S_WBSTAT) begin
                ust_r <= xf_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r   <= S_IDLE;
            tok_r     <= '0;
            xf_r      <= '0;
            idx_r     <= '0;
            pp_r      <= 1'b0;
            stat_r    <= '0;
            cap_r     <= '0;
            cnt_r     <= '0;
            base_r    <= '0;
            own_r     <= 1'b0;
            acc_r     <= 1'b0;
            stall_r   <= 1'b0;
            ovf_r     <= 1'b0;
            hs_pend_r <= 1'b0;
            hs_r      <= HS_ACK;
            tx_data_r <= '0;
        end else if (ce) begin
            unique case (state_r)
                S_IDLE: if (tok_take) begin
                    tok_r     <= tok;
                    xf_r      <= '{ep: tok.ep, dir_in: dir_in_w,
                                   odd: pp_w && ptr_bit};
                    idx_r     <= idx_w;
                    pp_r      <= pp_w;
                    cnt_r     <= '0;
                    ovf_r     <= 1'b0;
                    hs_pend_r <= 1'b0;
                    state_r   <= S_STAT;
                end
                S_STAT: begin
                    stat_r  <= eng_q;
                    state_r <= S_CNT;
                end
                S_CNT: begin
                    cap_r   <= {stat_r[ST_CNT_HI:0], eng_q};
                    state_r <= S_ADRL;
                end
                S_ADRL: begin
                    base_r[7:0] <= eng_q;
                    state_r     <= S_ADRH;
                end
                S_ADRH: begin
                    base_r[15:8] <= eng_q;
                    own_r   <= owned_w;
                    // A SETUP token overrides a buffer stall
                    acc_r   <= owned_w
                               && (!stat_r[ST_STALL] || setup_w);
                    stall_r <= owned_w && stat_r[ST_STALL] && !setup_w;
                    if (!xf_r.dir_in) begin
                        state_r <= S_RX;
                    end else if (!owned_w) begin
                        hs_r    <= HS_NAK;
                        state_r <= S_HS;
                    end else if (stat_r[ST_STALL]) begin
                        hs_r    <= HS_STALL;
                        state_r <= S_HS;
                    end else if (cap_r == '0) begin
                        state_r <= S_TX;
                    end else begin
                        state_r <= S_TXLD;
                    end
                end
                S_RX: if (rx_valid) begin
                    if (rx_byte && full) begin
                        ovf_r <= 1'b1;
                    end else if (rx_byte && acc_r) begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                    if (rx_last) begin
                        if (!own_r) begin
                            hs_r    <= HS_NAK;
                            state_r <= S_HS;
                        end else if (stall_r) begin
                            hs_r    <= HS_STALL;
                            state_r <= S_HS;
                        end else if (ovf_r || (rx_byte && full)) begin
                            hs_r    <= HS_NAK;
                            state_r <= S_HS;
                        end else if (tog_bad) begin
                            // Acknowledged but descriptor left armed
                            hs_r    <= HS_ACK;
                            state_r <= S_HS;
                        end else begin
                            hs_r      <= HS_ACK;
                            hs_pend_r <= 1'b1;
                            state_r   <= S_WBCNT;
                        end
                    end
                end
                S_TXLD: begin
                    tx_data_r <= eng_q;
                    state_r   <= S_TX;
                end
                S_TX: if (tx_ready) begin
                    if (!tx_empty) begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                    state_r <= tx_last ? S_WBCNT : S_TXLD;
                end
                S_WBCNT: state_r <= S_WBSTAT;
                S_WBSTAT: state_r <= hs_pend_r ? S_HS : S_IDLE;
                S_HS: state_r <= S_IDLE;
            endcase
        end
    end

endmodule // usb_buffer_descriptor_engine

// file: verif/bd_engine_asserts.sv
module bd_engine_asserts
    import usb_bd_pkg::*;
(
    // Clock, reset, bus
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       avs_read,
    input wire logic       avs_waitrequest,
    // Engine stream side
    input wire logic       tok_valid,
    input wire tok_s       tok,
    input wire logic       tok_ready,
    input wire logic       rx_valid,
    input wire logic       rx_last,
    input wire logic       rx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       tx_empty,
    input wire logic       tx_ready,
    input wire logic       hs_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wire logic take    = tok_valid && tok_ready;
    wire logic in_tok  = take && tok.pid == PID_IN;
    wire logic out_tok = take && (tok.pid == PID_OUT || tok.pid == PID_SETUP);

    a_fetch_busy: assert property
        ((in_tok || out_tok) |=> !tok_ready [*4])
        else $error("engine idle during descriptor fetch");
    a_out_receive: assert property (out_tok |-> ##5 rx_ready)
        else $error("receive window not opened after fetch");
    a_in_answer: assert property
        (in_tok |-> ##[5:6] (tx_valid || hs_valid))
        else $error("no data or handshake after IN token");
    a_tx_hold: assert property
        (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_last}))
        else $error("IN beat changed before it was taken");
    a_rx_end_hs: assert property
        (rx_valid && rx_ready && rx_last |-> ##[1:3] hs_valid)
        else $error("no handshake after OUT packet");
    a_hs_pulse: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    a_idle_quiet: assert property
        (tok_ready |-> !rx_ready && !tx_valid)
        else $error("data moving while engine idle");
    a_empty_last: assert property (tx_valid && tx_empty |-> tx_last)
        else $error("zero-length beat not marked last");
    a_last_ends: assert property
        (tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("IN stream ran past its last beat");
    a_read_answer: assert property
        (avs_read && avs_waitrequest |-> ##[1:40] !avs_waitrequest)
        else $error("register read never answered");

    cover property (out_tok ##5 rx_ready);
    cover property (in_tok ##6 tx_valid);
    cover property (tx_valid && !tx_ready);
endmodule // bd_engine_asserts

bind usb_buffer_descriptor_engine bd_engine_asserts u_chk (
    .clk(clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid), .tok(tok),
    .tok_ready(tok_ready), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_empty(tx_empty), .tx_ready(tx_ready),
    .hs_valid(hs_valid)
);

// file: verif/testbench.sv
module testbench
    import usb_bd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic [7:0]  rx_data, tx_data;
    logic        avs_waitrequest, tok_valid, tok_ready, rx_valid, rx_last;
    logic        rx_empty, rx_data1, rx_ready, tx_valid, tx_last, tx_empty;
    logic        tx_ready, hs_valid;
    tok_s        tok;
    hs_e         hs_code;
    int          miscompares = 0;
    int          n_checks = 0;
    // Entries are {mode, endpoint, descriptor} for IN tokens
    logic [9:0]  map [8] = '{
        {2'h0, 3'h7, 5'h0F},
        {2'h1, 3'h0, 5'h02}, {2'h1, 3'h5, 5'h0C},
        {2'h2, 3'h7, 5'h1E}, {2'h2, 3'h0, 5'h02},
        {2'h3, 3'h0, 5'h01}, {2'h3, 3'h1, 5'h04}, {2'h3, 3'h7, 5'h1C}
    };

    always #4 clk = ~clk;

    usb_buffer_descriptor_engine dut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid),
        .tok(tok), .tok_ready(tok_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_empty(rx_empty),
        .rx_data1(rx_data1), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_empty(tx_empty),
        .tx_ready(tx_ready), .hs_valid(hs_valid), .hs_code(hs_code)
    );

    usb_host_model host (
        .clk(clk), .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_empty(rx_empty), .rx_data1(rx_data1), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_empty(tx_empty),
        .tx_ready(tx_ready), .hs_valid(hs_valid), .hs_code(hs_code)
    );

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until waitrequest is seen low; one idle edge after
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        // Values seen here are those that stood up to this edge
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, q, exp);
    endtask

    function automatic logic [11:0] ra(input int b);
        return 12'(b * 4);
    endfunction

    task automatic bd(input int n, input logic [7:0] st, cnt,
                      input logic [8:0] adr);
        wr(ra(4 * n + 1), cnt);
        wr(ra(4 * n + 2), adr[7:0]);
        wr(ra(4 * n + 3), {7'h0, adr[8]});
        wr(ra(4 * n), st);
    endtask

    task automatic mode(input logic [1:0] m);
        wr(12'h800, {6'h03, m});
        wr(12'h800, {6'h01, m});
    endtask

    task automatic settle;
        do @(negedge clk); while (tok_ready !== 1'b1);
        @(posedge clk);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd("config", 12'h800, 32'h0);
        rd("xfer status", 12'h804, 32'h0);
        wr(12'hC00, 8'h5A);
        rd("unmapped", 12'hC00, 32'h0);
        mode(MODE_NONE);
        $display("test registers done");
        // Wrong toggle ignored while the check is off
        bd(2, 8'h81, 8'h04, 9'h100);
        host.token(PID_OUT, 3'h1);
        host.data(3, 8'hA0, 1'b1);
        settle();
        chk("out hs", host.hs_got, HS_ACK);
        rd("out stat", ra(8), {26'h0, PID_OUT, 2'b00});
        rd("out cnt", ra(9), 32'h3);
        for (int i = 0; i < 3; i++)
            rd("out buf", ra(256 + i), 32'hA0 + i);
        rd("transfer_status_register out", 12'h804, 32'h08);
        bd(2, 8'h80, 8'h02, 9'h100);
        host.token(PID_OUT, 3'h1);
        host.data(3, 8'hB0, 1'b0);
        settle();
        chk("big hs", host.hs_got, HS_NAK);
        rd("big cnt", ra(9), 32'h02);
        rd("big stat", ra(8), 32'h80);
        bd(2, 8'hC8, 8'h04, 9'h100);
        host.token(PID_OUT, 3'h1);
        host.data(1, 8'hC0, 1'b0);
        settle();
        chk("tog hs", host.hs_got, HS_ACK);
        rd("tog stat", ra(8), 32'hC8);
        $display("test out done");
        mode(MODE_ALL);
        for (int i = 0; i < 3; i++)
            wr(ra(384 + i), 8'h30 + 8'(i));
        bd(10, 8'hC0, 8'h02, 9'h180);
        bd(11, 8'h80, 8'h01, 9'h182);
        host.slow <= 1'b1;
        repeat (2) begin
            host.token(PID_IN, 3'h2);
            settle();
        end
        chk("in bytes", host.txq.size(), 3);
        for (int i = 0; i < 3; i++)
            chk("in data", host.txq[i], 8'h30 + i);
        rd("even stat", ra(40), 32'h64);
        rd("even cnt", ra(41), 32'h02);
        rd("odd stat", ra(44), 32'h24);
        rd("transfer_status_register odd", 12'h804, 32'h16);
        // Odd slot armed again: only an even pointer gives a NAK
        bd(11, 8'h80, 8'h01, 9'h182);
        host.token(PID_IN, 3'h2);
        settle();
        chk("back to even", host.hs_got, HS_NAK);
        $display("test ping-pong done");
        for (int i = 0; i < 8; i++) begin
            mode(map[i][9:8]);
            bd(map[i][4:0], 8'h80, 8'h00, 9'h1A0);
            host.token(PID_IN, map[i][7:5]);
            settle();
            rd("mapped stat", ra(4 * map[i][4:0]), 32'h24);
        end
        $display("test mapping done");
        // Stalled IN keeps the descriptor; SETUP overrides the stall
        bd(1, 8'h84, 8'h00, 9'h1A0);
        host.token(PID_IN, 3'h0);
        settle();
        chk("stall hs", host.hs_got, HS_STALL);
        rd("stall stat", ra(4), 32'h84);
        bd(0, 8'h84, 8'h02, 9'h1A0);
        host.token(PID_SETUP, 3'h0);
        host.data(2, 8'h11, 1'b1);
        settle();
        chk("setup hs", host.hs_got, HS_ACK);
        rd("setup stat", ra(0), 32'h34);
        rd("setup cnt", ra(1), 32'h02);
        $display("test stall done");
        conclude();
    end
endmodule // testbench

// file: verif/usb_host_model.sv
module usb_host_model
    import usb_bd_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Tokens and OUT data
    output logic            tok_valid,
    output tok_s            tok,
    input  wire logic       tok_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_last,
    output logic            rx_empty,
    output logic            rx_data1,
    input  wire logic       rx_ready,
    // IN data and handshake
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_empty,
    output logic            tx_ready,
    input  wire logic       hs_valid,
    input  wire hs_e        hs_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       slow;
    hs_e        hs_got;
    logic [7:0] txq[$];

    initial begin
        {tok_valid, rx_valid, rx_last, rx_empty, rx_data1} = '0;
        tok = '0;
        rx_data = 8'h00;
        slow = 1'b0;
    end

    // Slow sink refuses every other cycle
    always @(posedge clk) tx_ready <= slow ? !tx_ready : 1'b1;

    // Sampled mid-cycle, where the engine outputs have settled
    always @(negedge clk) begin
        if (tx_valid && tx_ready && !tx_empty)
            txq.push_back(tx_data);
        if (hs_valid)
            hs_got = hs_code;
    end

    task automatic token(input logic [3:0] pid, input logic [EP_W-1:0] ep);
        hs_got = hs_e'(2'h3);
        tok_valid <= 1'b1;
        tok <= '{pid: pid, ep: ep};
        do @(negedge clk); while (tok_ready !== 1'b1);
        @(posedge clk);
        tok_valid <= 1'b0;
        tok <= '{pid: 4'h0, ep: ~ep};
    endtask

    task automatic data(input int n, input logic [7:0] b0, input logic d1);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= b0 + 8'(i);
            rx_last <= (i == n - 1);
            rx_data1 <= d1;
            do @(negedge clk); while (rx_ready !== 1'b1);
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule // usb_host_model
